//--- rtl/hpfd_pkg.sv
// constants shared by the offset-removal high-pass filter block
// assumes a single 250 MHz system clock and a synchronous active-high reset
package hpfd_pkg;
    // sample and channel widths
    localparam int DATA_W = 16;
    localparam int CHAN_W = 6;
    localparam int SEL_W = 4;
    // amplifier channels are numbered 0 up to this limit, exclusive
    localparam int NUM_AMP_CH = 32;
    localparam logic [CHAN_W-1:0] AMP_CH_LIMIT = 6'h20;
    // filter state: integer part in the top bits, fraction below
    localparam int FRAC_W = 16;
    localparam int ACC_W = DATA_W + FRAC_W;
    // value of every filter state after reset; a clear starts its channel's update from it
    localparam logic [ACC_W-1:0] STATE_RST = 32'h0000_0000;
    // 16-bit saturation limits
    localparam logic [DATA_W-1:0] SAT_MAX = 16'h7fff;
    localparam logic [DATA_W-1:0] SAT_MIN = 16'h8000;
    localparam logic [FRAC_W-1:0] FRAC_ZERO = 16'h0000;
endpackage : hpfd_pkg

//--- rtl/hpfd_skid.sv
// two-entry result buffer with valid and ready on both sides
// assumes the source holds data stable while valid is high and ready low
module hpfd_skid (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    hpfd_strm_if.snk in_s,
    hpfd_strm_if.src out_s
);
    import hpfd_pkg::*;

    logic out_valid;
    logic [DATA_W-1:0] out_data;
    logic [CHAN_W-1:0] out_chan;
    logic skid_valid;
    logic [DATA_W-1:0] skid_data;
    logic [CHAN_W-1:0] skid_chan;
    logic push;
    logic pop;

    ////////////////////////////////////////////////////////////////////////
    // handshakes: accept while the spare entry is free
    assign in_s.ready = !skid_valid;
    assign push = in_s.valid && !skid_valid;
    assign pop = out_valid && out_s.ready;
    assign out_s.valid = out_valid;
    assign out_s.data = out_data;
    assign out_s.chan = out_chan;

    // head entry, drives the output straight from flops
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            out_valid <= 1'b0;
            out_data <= '0;
            out_chan <= '0;
        end else if (!out_valid || pop) begin
            if (skid_valid) begin
                out_valid <= 1'b1;
                out_data <= skid_data;
                out_chan <= skid_chan;
            end else begin
                out_valid <= push;
                if (push) begin
                    out_data <= in_s.data;
                    out_chan <= in_s.chan;
                end
            end
        end
    end

    // spare entry, catches a word while the receiver stalls
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            skid_valid <= 1'b0;
            skid_data <= '0;
            skid_chan <= '0;
        end else if (skid_valid) begin
            if (!out_valid || pop) begin
                skid_valid <= 1'b0;
            end
        end else if (push && out_valid && !pop) begin
            skid_valid <= 1'b1;
            skid_data <= in_s.data;
            skid_chan <= in_s.chan;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // a stalled word stays put until taken
    out_hold_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        out_valid && !out_s.ready |=> out_valid && $stable(out_data)
            && $stable(out_chan))
        else $error("stalled output word changed");

    // buffer fills under back-pressure
    buf_full_c: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        skid_valid && out_valid && !out_s.ready);
endmodule // hpfd_skid

//--- rtl/hpfd_strm_if.sv
// result stream carrier between the filter datapath and its output buffer
// assumes both ends run on the same system clock
interface hpfd_strm_if;
    logic valid;
    logic ready;
    logic [hpfd_pkg::DATA_W-1:0] data;
    logic [hpfd_pkg::CHAN_W-1:0] chan;
    modport src (output valid, output data, output chan, input ready);
    modport snk (input valid, input data, input chan, output ready);
endinterface : hpfd_strm_if

//--- rtl/hpfd_top.sv
// per-channel offset-removal high-pass filter with optional rectification
// assumes conversion results arrive from same-clock command logic, one per
// chip-select fall, and that the receiver may stall the result stream

// Notes on behaviour
// R1: filter applies only while hpf_enable is one; otherwise samples skip the filter, though rectify still applies
// R2: only channels 0 to 31 are filtered; others return unchanged
// R3: each amplifier channel keeps its own independent filter state
// R4: cutoff select N gives pole 1-2^-N, so cutoff ln(2^N/(2^N-1))/2pi
// R5: coefficient spans about 0.1103 at N=1 to 0.000004857 at N=15
// R6: cutoff scales with each channel's own sample rate
// R7: select zero makes output current minus previous sample of the channel
// R8: filtered output saturates at 16-bit limits, never wraps
// R9: a channel's state changes only on conversions of that channel
// R10: host converts every amplifier channel at one steady rate
// R11: command clear bit zeroes that channel's state; host uses it to recover
// R12: rectify enable replaces amplifier results with their absolute value
// R13: host should enable the filter whenever rectification is used
// R14: each conversion instant is one accepted result; host timing sets rate
// R15: rectification acts on the saturated filter output
// R16: absolute value of the most negative value saturates to max positive
module hpfd_top (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic hpf_enable_i,
    input wire logic rectify_enable_i,
    input wire logic [hpfd_pkg::SEL_W-1:0] cutoff_sel_i,
    input wire logic conv_valid_i,
    output logic conv_ready_o,
    input wire logic [hpfd_pkg::CHAN_W-1:0] conv_chan_i,
    input wire logic conv_clear_i,
    input wire logic [hpfd_pkg::DATA_W-1:0] conv_data_i,
    output logic res_valid_o,
    input wire logic res_ready_i,
    output logic [hpfd_pkg::CHAN_W-1:0] res_chan_o,
    output logic [hpfd_pkg::DATA_W-1:0] res_data_o
);
    import hpfd_pkg::*;

    // clip a 17-bit signed value into 16 bits
    function automatic logic [DATA_W-1:0] sat16(input logic [DATA_W:0] v);
        logic [DATA_W-1:0] r;
        r = v[DATA_W-1:0];
        if (v[DATA_W] != v[DATA_W-1]) begin
            r = v[DATA_W] ? SAT_MIN : SAT_MAX;
        end
        return r;
    endfunction

    // absolute value with the most negative input pinned to max
    function automatic logic [DATA_W-1:0] abs16(input logic [DATA_W-1:0] v);
        logic [DATA_W-1:0] r;
        r = v;
        if (v == SAT_MIN) begin
            r = SAT_MAX;
        end else if (v[DATA_W-1]) begin
            r = DATA_W'(~v + 1'b1);
        end
        return r;
    endfunction

    logic signed [ACC_W-1:0] state_q [NUM_AMP_CH];
    logic [NUM_AMP_CH*ACC_W-1:0] state_flat;
    logic is_amp;
    logic push;
    logic [4:0] chan_idx;
    logic signed [ACC_W-1:0] state_cur;
    logic signed [ACC_W-1:0] state_use;
    logic signed [ACC_W:0] x_acc;
    logic signed [ACC_W:0] diff_full;
    logic signed [ACC_W:0] step;
    logic signed [ACC_W:0] sum_full;
    logic [ACC_W-1:0] next_state;
    logic state_we;
    logic [DATA_W:0] hp_wide;
    logic [DATA_W-1:0] hp_sat;
    logic [DATA_W-1:0] filt;
    logic [DATA_W-1:0] rect;
    logic [DATA_W-1:0] push_data;

    hpfd_strm_if in_bus ();
    hpfd_strm_if out_bus ();

    ////////////////////////////////////////////////////////////////////////
    // channel decode and acceptance
    assign chan_idx = conv_chan_i[4:0];
    // R2: amplifier range check
    assign is_amp = conv_chan_i < AMP_CH_LIMIT;
    // R14: one accepted word per conversion instant
    assign push = conv_valid_i && in_bus.ready;
    assign conv_ready_o = in_bus.ready;

    // selected channel state, forced to zero by the clear bit
    assign state_cur = state_q[chan_idx];
    // R11: clear zeroes state before use
    assign state_use = conv_clear_i ? $signed(STATE_RST) : state_cur;

    // sample widened to the state format
    assign x_acc = {conv_data_i[DATA_W-1], conv_data_i, FRAC_ZERO};
    // error between sample and tracked baseline
    assign diff_full = x_acc - {state_use[ACC_W-1], state_use};
    // R4: baseline moves by 2^-N of the error, pole at 1-2^-N
    // R5: coefficient halves with each step of the select
    // R7: select zero copies the sample, output is a plain difference
    assign step = diff_full >>> cutoff_sel_i;
    assign sum_full = {state_use[ACC_W-1], state_use} + step;
    // state is held at zero by a clear while the filter is off
    assign next_state = hpf_enable_i ? sum_full[ACC_W-1:0] : STATE_RST;

    // integer part of the filter output
    assign hp_wide = diff_full[ACC_W:FRAC_W];
    // R8: hard limit at 16-bit range
    assign hp_sat = sat16(hp_wide);
    // R1: bypass while the filter is off
    assign filt = hpf_enable_i ? hp_sat : conv_data_i;
    // R15: rectify after saturation
    // R12: absolute value mode
    // R16: most negative pins to max
    assign rect = rectify_enable_i ? abs16(filt) : filt;
    // R2: non-amplifier results pass untouched
    assign push_data = is_amp ? rect : conv_data_i;

    ////////////////////////////////////////////////////////////////////////
    // R9: write only on a conversion of this channel
    // R6: updates per channel conversion, so cutoff follows its own rate
    assign state_we = push && is_amp && (hpf_enable_i || conv_clear_i);

    // R3: one independent state register per amplifier channel
    genvar g;
    generate
        for (g = 0; g < NUM_AMP_CH; g++) begin : g_state
            always_ff @(posedge clk_sys_i) begin
                if (sys_rst_i) begin
                    state_q[g] <= $signed(STATE_RST);
                end else if (state_we && chan_idx == 5'(g)) begin
                    state_q[g] <= $signed(next_state);
                end
            end
            assign state_flat[g*ACC_W +: ACC_W] = state_q[g];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // result stream into the two-entry buffer
    assign in_bus.valid = conv_valid_i;
    assign in_bus.data = push_data;
    assign in_bus.chan = conv_chan_i;
    assign out_bus.ready = res_ready_i;
    assign res_valid_o = out_bus.valid;
    assign res_data_o = out_bus.data;
    assign res_chan_o = out_bus.chan;

    hpfd_skid u_skid (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .in_s(in_bus.snk),
        .out_s(out_bus.src)
    );

    ////////////////////////////////////////////////////////////////////////
    // checks on the datapath
    // state expected after a clear: the sample scaled by 2^-N
    logic signed [ACC_W:0] clear_state_exp;
    assign clear_state_exp = x_acc >>> cutoff_sel_i;

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (sys_rst_i);

    bypass_raw_a: assert property ( // R1
        push && !hpf_enable_i && !rectify_enable_i |->
            in_bus.data == conv_data_i)
        else $error("disabled filter altered a sample");

    aux_raw_a: assert property ( // R2
        push && !is_amp |-> in_bus.data == conv_data_i)
        else $error("non-amplifier result altered");

    other_chan_a: assert property ( // R9
        !state_we |=> $stable(state_flat))
        else $error("filter state changed without a conversion");

    clear_zero_a: assert property ( // R11
        push && is_amp && conv_clear_i && hpf_enable_i
            && !rectify_enable_i |-> in_bus.data == conv_data_i
            ##1 state_q[$past(chan_idx)] == $past(clear_state_exp))
        else $error("clear did not zero the channel state");

    diff_mode_a: assert property ( // R7
        push && is_amp && hpf_enable_i && cutoff_sel_i == 4'h0 ##1
        push && chan_idx == $past(chan_idx) && is_amp && hpf_enable_i
            && cutoff_sel_i == 4'h0 && !conv_clear_i && !rectify_enable_i
        |-> in_bus.data == sat16({conv_data_i[DATA_W-1], conv_data_i}
            - {$past(conv_data_i[DATA_W-1]), $past(conv_data_i)}))
        else $error("differentiator output wrong");

    sat_high_a: assert property ( // R8
        push && is_amp && hpf_enable_i && !rectify_enable_i
            && !hp_wide[DATA_W] && hp_wide[DATA_W-1] |->
            in_bus.data == SAT_MAX)
        else $error("positive overflow wrapped");

    sat_low_a: assert property ( // R8
        push && is_amp && hpf_enable_i && !rectify_enable_i
            && hp_wide[DATA_W] && !hp_wide[DATA_W-1] |->
            in_bus.data == SAT_MIN)
        else $error("negative overflow wrapped");

    rect_pos_a: assert property ( // R12
        push && is_amp && rectify_enable_i |-> !in_bus.data[DATA_W-1])
        else $error("rectified result negative");

    rect_order_a: assert property ( // R15
        push && is_amp && rectify_enable_i && hpf_enable_i && conv_clear_i
            |-> in_bus.data == abs16(conv_data_i))
        else $error("rectify not applied to filter output");

    rect_min_a: assert property ( // R16
        push && is_amp && rectify_enable_i && !hpf_enable_i
            && conv_data_i == SAT_MIN |-> in_bus.data == SAT_MAX)
        else $error("most negative value wrapped");

    clear_seen_c: cover property (push && is_amp && conv_clear_i);
    rect_filt_c: cover property (push && is_amp && rectify_enable_i
        && hpf_enable_i);
    sat_seen_c: cover property (push && is_amp && hpf_enable_i
        && hp_wide[DATA_W] != hp_wide[DATA_W-1]);
    stall_c: cover property (conv_valid_i && !conv_ready_o);
endmodule // hpfd_top

//--- tb/hpfd_host_model.sv
// behavioural conversion host offering one result per chip-select fall
// assumes the block's clock; the bench calls its tasks at clock edges
module hpfd_host_model (
    input wire logic clk_sys_i,
    input wire logic conv_ready_i,
    output logic conv_valid_o,
    output logic [hpfd_pkg::CHAN_W-1:0] conv_chan_o,
    output logic conv_clear_o,
    output logic [hpfd_pkg::DATA_W-1:0] conv_data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import hpfd_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // idle lines at time zero
    initial begin
        conv_valid_o = 1'b0;
        conv_chan_o = 6'h00;
        conv_clear_o = 1'b0;
        conv_data_o = 16'h0000;
    end

    ////////////////////////////////////////////////////////////////////////
    // one conversion
    // command held until taken; clear bit forces state recovery
    task automatic send(input logic [CHAN_W-1:0] ch, input logic clr,
                        input logic [DATA_W-1:0] x);
        conv_valid_o <= 1'b1;
        conv_chan_o <= ch;
        conv_clear_o <= clr;
        conv_data_o <= x;
        @(posedge clk_sys_i iff conv_ready_i === 1'b1);
    endtask

    // released lines show inverted garbage, not the last word
    task automatic release_bus();
        conv_valid_o <= 1'b0;
        conv_chan_o <= ~conv_chan_o;
        conv_clear_o <= ~conv_clear_o;
        conv_data_o <= ~conv_data_o;
    endtask
endmodule // hpfd_host_model

//--- tb/hpfd_top_tb_top.sv
// self-checking bench for the per-channel high-pass filter block
// assumes the host model on the conversion side, bench as result receiver
module hpfd_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import hpfd_pkg::*;

    typedef struct packed {
        logic en;
        logic rect;
        logic [SEL_W-1:0] sel;
        logic [CHAN_W-1:0] ch;
        logic clr;
        logic [DATA_W-1:0] x;
        logic [DATA_W-1:0] y;
    } hpfd_row_t;

    logic clk_sys_i;
    logic sys_rst_i;
    logic hpf_enable_i;
    logic rectify_enable_i;
    logic [SEL_W-1:0] cutoff_sel_i;
    logic conv_valid_i;
    logic conv_ready_o;
    logic [CHAN_W-1:0] conv_chan_i;
    logic conv_clear_i;
    logic [DATA_W-1:0] conv_data_i;
    logic res_valid_o;
    logic res_ready_i;
    logic [CHAN_W-1:0] res_chan_o;
    logic [DATA_W-1:0] res_data_o;
    int failures = 0;
    int total_checks = 0;

    // ordinary cases: config, command, raw word, expected word
    hpfd_row_t rows [23] = '{
        '{1'b0, 1'b0, 4'h0, 6'h00, 1'b0, 16'h1234, 16'h1234},
        '{1'b1, 1'b0, 4'h0, 6'h00, 1'b0, 16'h0100, 16'h0100},
        '{1'b1, 1'b0, 4'h0, 6'h01, 1'b0, 16'h0050, 16'h0050},
        '{1'b1, 1'b0, 4'h0, 6'h00, 1'b0, 16'h0180, 16'h0080},
        '{1'b1, 1'b0, 4'h0, 6'h01, 1'b0, 16'h0040, 16'hfff0},
        '{1'b1, 1'b0, 4'h0, 6'h02, 1'b0, 16'h7fff, 16'h7fff},
        '{1'b1, 1'b0, 4'h0, 6'h02, 1'b0, 16'h8000, 16'h8000},
        '{1'b1, 1'b0, 4'h0, 6'h02, 1'b0, 16'h7fff, 16'h7fff},
        '{1'b1, 1'b1, 4'h0, 6'h02, 1'b0, 16'h8000, 16'h7fff},
        '{1'b1, 1'b1, 4'h0, 6'h00, 1'b0, 16'h0100, 16'h0080},
        '{1'b1, 1'b1, 4'h0, 6'h28, 1'b0, 16'hff00, 16'hff00},
        '{1'b1, 1'b0, 4'h0, 6'h00, 1'b1, 16'h0030, 16'h0030},
        '{1'b1, 1'b0, 4'h1, 6'h03, 1'b0, 16'h0100, 16'h0100},
        '{1'b1, 1'b0, 4'h1, 6'h03, 1'b0, 16'h0100, 16'h0080},
        '{1'b1, 1'b0, 4'h1, 6'h03, 1'b0, 16'h0100, 16'h0040},
        '{1'b1, 1'b0, 4'hf, 6'h04, 1'b0, 16'h4000, 16'h4000},
        '{1'b1, 1'b0, 4'hf, 6'h04, 1'b0, 16'h4000, 16'h3fff},
        '{1'b0, 1'b1, 4'h0, 6'h05, 1'b0, 16'hfffe, 16'h0002},
        '{1'b0, 1'b1, 4'h0, 6'h21, 1'b0, 16'h8000, 16'h8000},
        '{1'b0, 1'b1, 4'h0, 6'h06, 1'b0, 16'h8000, 16'h7fff},
        '{1'b1, 1'b1, 4'h0, 6'h07, 1'b1, 16'hff80, 16'h0080},
        '{1'b0, 1'b0, 4'h1, 6'h03, 1'b0, 16'h0000, 16'h0000},
        '{1'b1, 1'b0, 4'h1, 6'h03, 1'b0, 16'h0100, 16'h0020}
    };

    ////////////////////////////////////////////////////////////////////////
    // clock, block and host
    initial begin
        clk_sys_i = 1'b0;
        forever #2 clk_sys_i = ~clk_sys_i;
    end

    hpfd_top DUT (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .hpf_enable_i(hpf_enable_i), .rectify_enable_i(rectify_enable_i),
        .cutoff_sel_i(cutoff_sel_i), .conv_valid_i(conv_valid_i),
        .conv_ready_o(conv_ready_o), .conv_chan_i(conv_chan_i),
        .conv_clear_i(conv_clear_i), .conv_data_i(conv_data_i),
        .res_valid_o(res_valid_o), .res_ready_i(res_ready_i),
        .res_chan_o(res_chan_o), .res_data_o(res_data_o));

    hpfd_host_model host (.clk_sys_i(clk_sys_i),
        .conv_ready_i(conv_ready_o), .conv_valid_o(conv_valid_i),
        .conv_chan_o(conv_chan_i), .conv_clear_o(conv_clear_i),
        .conv_data_o(conv_data_i));

    ////////////////////////////////////////////////////////////////////////
    // compare, receive and close
    task automatic check(input string name, input logic [DATA_W-1:0] seen,
                         input logic [DATA_W-1:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // waits for a taken result word, bounded
    task automatic take(input logic [CHAN_W-1:0] ch,
                        input logic [DATA_W-1:0] y);
        int n = 0;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (!(res_valid_o === 1'b1 && res_ready_i === 1'b1) && n < 20);
        check("res_valid", {15'h0000, res_valid_o}, 16'h0001);
        check("res_chan", {10'h000, res_chan_o}, {10'h000, ch});
        check("res_data", res_data_o, y);
    endtask

    task automatic complete_run();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // hang guard
    initial begin
        repeat (2000) @(posedge clk_sys_i);
        failures++;
        complete_run();
    end

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        sys_rst_i = 1'b1;
        hpf_enable_i = 1'b0;
        rectify_enable_i = 1'b0;
        cutoff_sel_i = 4'h0;
        res_ready_i = 1'b1;
        repeat (8) @(posedge clk_sys_i);
        check("reset_valid", {15'h0000, res_valid_o}, 16'h0000);
        check("reset_ready", {15'h0000, conv_ready_o}, 16'h0001);
        sys_rst_i <= 1'b0;
        @(posedge clk_sys_i);
        foreach (rows[i]) begin
            hpf_enable_i <= rows[i].en;
            rectify_enable_i <= rows[i].rect;
            cutoff_sel_i <= rows[i].sel;
            host.send(rows[i].ch, rows[i].clr, rows[i].x);
            host.release_bus();
            take(rows[i].ch, rows[i].y);
        end
        // back-to-back differentiator pair on one channel
        hpf_enable_i <= 1'b1;
        rectify_enable_i <= 1'b0;
        cutoff_sel_i <= 4'h0;
        res_ready_i <= 1'b0;
        host.send(6'h08, 1'b0, 16'h0010);
        host.send(6'h08, 1'b0, 16'h0030);
        host.release_bus();
        #1 check("conv_ready", {15'h0000, conv_ready_o}, 16'h0000);
        @(posedge clk_sys_i) res_ready_i <= 1'b1;
        take(6'h08, 16'h0010);
        take(6'h08, 16'h0020);
        hpf_enable_i <= 1'b1;
        cutoff_sel_i <= 4'h0;
        res_ready_i <= 1'b0;
        host.send(6'h00, 1'b0, 16'h0007);
        host.release_bus();
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        check("rst_valid", {15'h0000, res_valid_o}, 16'h0000);
        sys_rst_i <= 1'b0;
        res_ready_i <= 1'b1;
        @(posedge clk_sys_i);
        host.send(6'h00, 1'b0, 16'h0005);
        host.release_bus();
        take(6'h00, 16'h0005);
        complete_run();
    end
endmodule // hpfd_top_tb_top
